/* adcc_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

`define ADCC_ADDR_W         8
`define ADCC_ADDR_SC1       8'h00
`define ADCC_ADDR_SC2       8'h04
`define ADCC_ADDR_RES_LO    8'h08
`define ADCC_ADDR_RES_HI    8'h0c
`define ADCC_ADDR_CMP_LO    8'h10
`define ADCC_ADDR_CMP_HI    8'h14

`define ADCC_SC1_DONE       7
`define ADCC_SC1_IRQEN      6
`define ADCC_SC1_CONT       5
`define ADCC_SEL_MSB        4
`define ADCC_SEL_LSB        0
`define ADCC_SC2_ACT        7
`define ADCC_SC2_TRG        6
`define ADCC_SC2_CMPEN      5
`define ADCC_SC2_CMPGE      4

`define ADCC_SEL_OFF        5'h1f
`define ADCC_SEL_LAST_PIN   5'h1b
`define ADCC_SEL_REFH       5'h1d
`define ADCC_SEL_REFL       5'h1e
`define ADCC_NUM_PINS       28

`define ADCC_RES_W          10
`define ADCC_RES_ZERO       10'h000
`define ADCC_RES_MSB_MASK   10'h200

`define ADCC_DIV_W          4
`define ADCC_DIV_LAST       4'h3
`define ADCC_SAMPLE_LAST    4'h3
`define ADCC_HTRANS_NONSEQ  2'h2
`define ADCC_WORD_ZERO      32'h0000_0000

`endif

/* adcc_pkg.sv */
// shared types of the conversion controller
package adcc_pkg;

    // gray order along idle -> sample -> convert -> finish
    typedef enum logic [1:0] {
        sar_idle    = 2'h0,
        sar_sample  = 2'h1,
        sar_convert = 2'h3,
        sar_finish  = 2'h2
    } adcc_sar_state_type;

endpackage

/* adcc_chan_decode.sv */
// decode of the input select field into mux enables
`include "adcc_defs.svh"

module adcc_chan_decode (
    // select field
    input  wire logic [4:0]                 sel,
    // decoded enables
    output logic [`ADCC_NUM_PINS-1:0] pin_en,
    output logic                      refh_en,
    output logic                      refl_en,
    output logic                      enabled
);

    genvar g;
    generate
        for (g = 0; g < `ADCC_NUM_PINS; g = g + 1) begin : g_pin
            assign pin_en[g] = (sel == 5'(g));
        end
    endgenerate

    // reserved code selects nothing but keeps the converter powered
    assign refh_en = (sel == `ADCC_SEL_REFH);
    assign refl_en = (sel == `ADCC_SEL_REFL);
    assign enabled = (sel != `ADCC_SEL_OFF);

endmodule // adcc_chan_decode

/* adcc_sar.sv */
// successive approximation sequencer, one bit per conversion tick
`include "adcc_defs.svh"

module adcc_sar (
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // control
    input  wire logic                   tick,
    input  wire logic                   start,
    input  wire logic                   abort,
    input  wire logic                   comp_in,
    // status and analog drive
    output logic                        busy_r,
    output logic                        done_r,
    output logic                        sample_r,
    output logic [`ADCC_RES_W-1:0]      trial_r,
    output logic [`ADCC_RES_W-1:0]      result_r
);

    adcc_pkg::adcc_sar_state_type state_r, state_nxt;
    logic [`ADCC_DIV_W-1:0] cnt_r, cnt_nxt;
    logic [`ADCC_RES_W-1:0] mask_r, mask_nxt, trial_nxt, result_nxt;
    logic [`ADCC_RES_W-1:0] kept;

    // comparator high means input above the trial level: keep the bit
    assign kept = comp_in ? trial_r : (trial_r & ~mask_r);

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        mask_nxt   = mask_r;
        trial_nxt  = trial_r;
        result_nxt = result_r;
        case (state_r)
            adcc_pkg::sar_sample: begin
                if (tick) begin
                    cnt_nxt = cnt_r + 1'b1;
                    if (cnt_r == `ADCC_SAMPLE_LAST) begin
                        state_nxt = adcc_pkg::sar_convert;
                        mask_nxt  = `ADCC_RES_MSB_MASK;
                        trial_nxt = `ADCC_RES_MSB_MASK;
                    end
                end
            end
            adcc_pkg::sar_convert: begin
                if (tick) begin
                    mask_nxt  = mask_r >> 1;
                    trial_nxt = kept | (mask_r >> 1);
                    if (mask_r[0]) begin
                        state_nxt  = adcc_pkg::sar_finish;
                        result_nxt = kept;
                    end
                end
            end
            adcc_pkg::sar_finish: state_nxt = adcc_pkg::sar_idle;
            default:              state_nxt = adcc_pkg::sar_idle;
        endcase
        // a restart wins over the abort that comes with it
        if (abort) begin
            state_nxt = adcc_pkg::sar_idle;
        end
        if (start) begin
            state_nxt = adcc_pkg::sar_sample;
            cnt_nxt   = '0;
            trial_nxt = `ADCC_RES_ZERO;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= adcc_pkg::sar_idle;
            cnt_r    <= '0;
            mask_r   <= `ADCC_RES_ZERO;
            trial_r  <= `ADCC_RES_ZERO;
            result_r <= `ADCC_RES_ZERO;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            sample_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            mask_r   <= mask_nxt;
            trial_r  <= trial_nxt;
            result_r <= result_nxt;
            busy_r   <= (state_nxt == adcc_pkg::sar_sample) ||
                        (state_nxt == adcc_pkg::sar_convert);
            done_r   <= (state_nxt == adcc_pkg::sar_finish);
            sample_r <= (state_nxt == adcc_pkg::sar_sample);
        end
    end

endmodule // adcc_sar

/* adcc_top.sv */
// conversion control and status block with its register slave
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`include "adcc_defs.svh"

// Contract
// - a control-one write aborts, and in software trigger mode restarts unless the select is all ones
// - the done flag bit is read-only; the value written to it is ignored
// - compare off: a completed conversion sets the done flag unless a control-one write comes in the same cycle
// - compare on: done flag set only when the compare holds
// - control-one write or low result read clears the done flag
// - interrupt asserted while done flag and interrupt enable are set
// - continuous off: one conversion per write or per trigger
// - continuous on, software trigger: write starts repeating conversions
// - continuous on, hardware trigger: trigger starts repeating conversions
// - select codes pick inputs 0..27, reserved, high and low reference
// - all-ones select powers the converter off and isolates inputs
// - stopping with all-ones select runs no further conversion
// - single mode returns the converter to idle power after finishing
// - trigger select picks write start or hardware trigger start
// - active status set on start, cleared on completion or abort
// - compare is less-than, or greater-or-equal when selected
module adcc_top (
    // clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // ahb-lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic [31:0]                   hrdata,
    output logic                          hresp,
    // trigger and comparator
    input  wire logic                     hw_trigger_in,
    input  wire logic                     comp_in,
    // analog front end
    output logic [`ADCC_NUM_PINS-1:0]     analog_input_en,
    output logic                          ref_high_input_en,
    output logic                          ref_low_input_en,
    output logic                          converter_power_en,
    output logic                          sample_en,
    output logic [`ADCC_RES_W-1:0]        dac_trial,
    // interrupt
    output logic                          done_irq
);

    // select all ones, used for stored and written values
    function automatic logic sel_off(input logic [4:0] s);
        sel_off = (s == `ADCC_SEL_OFF);
    endfunction

    // ---- bus state ----
    logic                     rd_pend_r;
    logic                     wr_pend_r;
    logic [`ADCC_ADDR_W-1:0]  addr_r;
    logic                     hreadyout_r;
    logic [31:0]              hrdata_r;

    // ---- registers ----
    logic                     done_r, done_nxt;
    logic                     irqen_r;
    logic                     cont_r;
    logic [4:0]               sel_r;
    logic                     trg_r;
    logic                     cmpen_r;
    logic                     cmpge_r;
    logic [`ADCC_RES_W-1:0]   res_r;
    logic [`ADCC_RES_W-1:0]   cmpv_r;

    // ---- control state ----
    logic                     cont_run_r, cont_run_nxt;
    logic                     hw_prev_r;
    logic [`ADCC_DIV_W-1:0]   div_r;
    logic                     tick_r;
    logic                     irq_r;
    logic                     power_r;
    logic [`ADCC_NUM_PINS-1:0] pin_en_r;
    logic                     refh_r;
    logic                     refl_r;

    // ---- sequencer ----
    logic                     sar_busy;
    logic                     sar_done;
    logic                     sar_sample;
    logic [`ADCC_RES_W-1:0]   sar_trial;
    logic [`ADCC_RES_W-1:0]   sar_result;

    // ---- decode ----
    logic [`ADCC_NUM_PINS-1:0] dec_pin;
    logic                     dec_refh;
    logic                     dec_refl;
    logic                     dec_on;

    wire addr_ph  = hsel & hready & (htrans == `ADCC_HTRANS_NONSEQ |
                                     htrans == 2'h3);
    wire sc1_wr   = wr_pend_r & (addr_r == `ADCC_ADDR_SC1);
    wire sc2_wr   = wr_pend_r & (addr_r == `ADCC_ADDR_SC2);
    wire cml_wr   = wr_pend_r & (addr_r == `ADCC_ADDR_CMP_LO);
    wire cmh_wr   = wr_pend_r & (addr_r == `ADCC_ADDR_CMP_HI);
    wire rl_rd    = rd_pend_r & (addr_r == `ADCC_ADDR_RES_LO);

    wire [4:0] wsel    = hwdata[`ADCC_SEL_MSB:`ADCC_SEL_LSB];
    wire       wcont   = hwdata[`ADCC_SC1_CONT];
    wire       woff    = sel_off(wsel);
    wire       cur_off = sel_off(sel_r);

    // the trigger source gives one pulse per overflow; take its rising edge
    wire hw_edge  = hw_trigger_in & ~hw_prev_r;
    wire hw_start = hw_edge & trg_r & ~cur_off & ~sar_busy &
                    ~cont_run_r & ~sc1_wr;
    // software mode start on a write, hardware mode only arms
    wire sw_start = sc1_wr & ~woff & ~trg_r;
    wire restart  = sar_done & cont_run_r & ~sc1_wr;
    wire sar_start = sw_start | hw_start | restart;
    wire sar_abort = sc1_wr;

    // mode that the next run uses: a write carries its own bit
    wire cont_now = sc1_wr ? wcont : cont_r;

    always_comb begin
        cont_run_nxt = cont_run_r;
        if (sar_start) begin
            cont_run_nxt = cont_now;
        end else if (sc1_wr) begin
            cont_run_nxt = 1'b0;
        end
    end

    wire cmp_true = cmpge_r ? (sar_result >= cmpv_r)
                            : (sar_result <  cmpv_r);
    wire take     = sar_done & ~sc1_wr &
                    (~cmpen_r | cmp_true);
    wire done_clr = sc1_wr | rl_rd;

    // set wins over a result-read clear in the same cycle; a control-one write blocks the set
    assign done_nxt = take | (done_r & ~done_clr);

    wire irqen_nxt = sc1_wr ? hwdata[`ADCC_SC1_IRQEN] : irqen_r;

    // power stays up only while a run is active or a series continues
    wire power_nxt = ~cur_off & (sar_busy | cont_run_r |
                                 sar_start);

    wire [31:0] rd_mux =
        (addr_r == `ADCC_ADDR_SC1)    ? {24'h000000, done_r, irqen_r,
                                         cont_r, sel_r} :
        (addr_r == `ADCC_ADDR_SC2)    ? {24'h000000, sar_busy, trg_r,
                                         cmpen_r, cmpge_r, 4'h0} :
        (addr_r == `ADCC_ADDR_RES_LO) ? {24'h000000, res_r[7:0]} :
        (addr_r == `ADCC_ADDR_RES_HI) ? {30'h00000000, res_r[9:8]} :
        (addr_r == `ADCC_ADDR_CMP_LO) ? {24'h000000, cmpv_r[7:0]} :
        (addr_r == `ADCC_ADDR_CMP_HI) ? {30'h00000000, cmpv_r[9:8]} :
                                        `ADCC_WORD_ZERO;

    adcc_chan_decode u_dec (
        .sel     (sel_r),
        .pin_en  (dec_pin),
        .refh_en (dec_refh),
        .refl_en (dec_refl),
        .enabled (dec_on)
    );

    adcc_sar u_sar (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .tick     (tick_r),
        .start    (sar_start),
        .abort    (sar_abort),
        .comp_in  (comp_in),
        .busy_r   (sar_busy),
        .done_r   (sar_done),
        .sample_r (sar_sample),
        .trial_r  (sar_trial),
        .result_r (sar_result)
    );

    // bus: writes zero-wait, reads take one wait state so data is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r   <= 1'b0;
            wr_pend_r   <= 1'b0;
            addr_r      <= '0;
            hreadyout_r <= 1'b1;
            hrdata_r    <= `ADCC_WORD_ZERO;
        end else begin
            rd_pend_r   <= addr_ph & ~hwrite;
            wr_pend_r   <= addr_ph & hwrite;
            hreadyout_r <= ~(addr_ph & ~hwrite);
            if (addr_ph) begin
                addr_r <= haddr[`ADCC_ADDR_W-1:0];
            end
            if (rd_pend_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // control/status one; the done bit position of hwdata is ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqen_r <= 1'b0;
            cont_r  <= 1'b0;
            sel_r   <= `ADCC_SEL_OFF;
        end else if (sc1_wr) begin
            irqen_r <= hwdata[`ADCC_SC1_IRQEN];
            cont_r  <= wcont;
            sel_r   <= wsel;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trg_r   <= 1'b0;
            cmpen_r <= 1'b0;
            cmpge_r <= 1'b0;
        end else if (sc2_wr) begin
            trg_r   <= hwdata[`ADCC_SC2_TRG];
            cmpen_r <= hwdata[`ADCC_SC2_CMPEN];
            cmpge_r <= hwdata[`ADCC_SC2_CMPGE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmpv_r <= `ADCC_RES_ZERO;
        end else if (cml_wr) begin
            cmpv_r[7:0] <= hwdata[7:0];
        end else if (cmh_wr) begin
            cmpv_r[9:8] <= hwdata[1:0];
        end
    end

    // result holds the last conversion that passed the compare gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_r <= `ADCC_RES_ZERO;
        end else if (take) begin
            res_r <= sar_result;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r     <= 1'b0;
            cont_run_r <= 1'b0;
            hw_prev_r  <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            done_r     <= done_nxt;
            cont_run_r <= cont_run_nxt;
            hw_prev_r  <= hw_trigger_in;
            irq_r      <= done_nxt & irqen_nxt;
        end
    end

    // conversion clock enable from the bus clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= (div_r == `ADCC_DIV_LAST) ? '0 : div_r + 1'b1;
            tick_r <= (div_r == `ADCC_DIV_LAST);
        end
    end

    // front end enables; everything isolated when the select is all ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_r  <= 1'b0;
            pin_en_r <= '0;
            refh_r   <= 1'b0;
            refl_r   <= 1'b0;
        end else begin
            power_r  <= power_nxt;
            pin_en_r <= dec_on ? dec_pin : '0;
            refh_r   <= dec_refh;
            refl_r   <= dec_refl;
        end
    end

    assign hreadyout          = hreadyout_r;
    assign hrdata             = hrdata_r;
    assign hresp              = 1'b0;
    assign analog_input_en    = pin_en_r;
    assign ref_high_input_en  = refh_r;
    assign ref_low_input_en   = refl_r;
    assign converter_power_en = power_r;
    assign sample_en          = sar_sample;
    assign dac_trial          = sar_trial;
    assign done_irq           = irq_r;

endmodule // adcc_top

/* adcc_top_asserts.sv */
// protocol and behaviour checks bound to the conversion controller top
`include "adcc_defs.svh"

module adcc_top_asserts (
    // clock and reset
    input wire logic                      hclk,
    input wire logic                      hresetn,
    // bus
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic [31:0]               hwdata,
    input wire logic                      hready,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    // trigger and front end
    input wire logic                      hw_trigger_in,
    input wire logic [`ADCC_NUM_PINS-1:0] analog_input_en,
    input wire logic                      ref_high_input_en,
    input wire logic                      ref_low_input_en,
    input wire logic                      converter_power_en,
    input wire logic                      sample_en,
    input wire logic                      done_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       dp_wr_r;
    logic [7:0] dp_a_r;
    logic       hw_mode_r;
    logic       cont_r;
    logic       irq_en_r;
    logic [4:0] sel_r;
    logic [7:0] pwr_cnt_r;
    wire        take = hsel && hready && htrans[1];
    wire        sc1_wr = dp_wr_r && hready && dp_a_r == 8'h00;

    function automatic logic [29:0] exp_en(input logic [4:0] s);
        exp_en = '0;
        if (s < 5'h1c) exp_en[int'(s) + 2] = 1'b1;
        exp_en[1] = (s == 5'h1d);
        exp_en[0] = (s == 5'h1e);
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_a_r <= 8'h00;
            hw_mode_r <= 1'b0;
            cont_r <= 1'b0;
            irq_en_r <= 1'b0;
            sel_r <= 5'h1f;
        end else begin
            if (hready) dp_wr_r <= take && hwrite;
            if (hready) dp_a_r <= haddr[7:0];
            if (dp_wr_r && hready && dp_a_r == 8'h04) hw_mode_r <= hwdata[6];
            if (sc1_wr) cont_r <= hwdata[5];
            if (sc1_wr) irq_en_r <= hwdata[6];
            if (sc1_wr) sel_r <= hwdata[4:0];
        end
    end

    // a restart keeps power high, so the run length restarts with it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pwr_cnt_r <= 8'h00;
        else if (!converter_power_en || sc1_wr) pwr_cnt_r <= 8'h00;
        else if (pwr_cnt_r != 8'hff) pwr_cnt_r <= pwr_cnt_r + 8'h01;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_sw_start;
        sc1_wr && hwdata[4:0] != 5'h1f && !hw_mode_r |-> ##[1:8] sample_en;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("write did not start a conversion");
    property p_hw_wait;
        (sc1_wr && hw_mode_r && !hw_trigger_in) ##1 (!hw_trigger_in)[*8]
            |-> !sample_en;
    endproperty
    a_hw_wait: assert property (p_hw_wait)
        else $error("write started a conversion in trigger mode");
    property p_off;
        sc1_wr && hwdata[4:0] == 5'h1f
            |-> ##3 !converter_power_en && !sample_en;
    endproperty
    a_off: assert property (p_off)
        else $error("converter still powered after off");
    property p_decode;
        sc1_wr |-> ##3 {analog_input_en, ref_high_input_en,
                        ref_low_input_en} == exp_en(sel_r);
    endproperty
    a_decode: assert property (p_decode)
        else $error("input enables wrong");
    property p_clr; sc1_wr |-> ##2 !done_irq; endproperty
    a_clr: assert property (p_clr)
        else $error("write left done set");
    property p_rd_clr;
        take && !hwrite && haddr[7:0] == 8'h08 && !converter_power_en
            |-> ##3 !done_irq;
    endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("result read left done set");
    property p_irq; $rose(done_irq) |-> irq_en_r; endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt while disabled");
    property p_single; !cont_r |-> pwr_cnt_r < 8'd100; endproperty
    a_single: assert property (p_single)
        else $error("converter not idle after single conversion");
endmodule // adcc_top_asserts

bind adcc_top adcc_top_asserts u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .hw_trigger_in, .analog_input_en, .ref_high_input_en,
    .ref_low_input_en, .converter_power_en, .sample_en, .done_irq
);

/* adcc_front_model.sv */
// analog front end and periodic trigger source model
module adcc_front_model (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // from the converter
    input wire logic [27:0] analog_input_en,
    input wire logic        ref_high_input_en,
    input wire logic        ref_low_input_en,
    input wire logic        sample_en,
    input wire logic [9:0]  dac_trial,
    // from the bench
    input wire logic        trig_on,
    // to the converter
    output logic            comp_in,
    output logic            hw_trigger_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] lvl;
    logic [9:0] held_r;
    logic [7:0] tcnt_r;

    // isolated or reserved input reads as ground
    always_comb begin
        lvl = 10'h000;
        for (int i = 0; i < 28; i++)
            if (analog_input_en[i]) lvl = 10'(i * 37 + 5);
        if (ref_high_input_en) lvl = 10'h3ff;
    end

    always_ff @(posedge hclk) if (sample_en) held_r <= lvl;
    assign comp_in = held_r >= dac_trial;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcnt_r <= 8'h00;
            hw_trigger_in <= 1'b0;
        end else begin
            tcnt_r <= (tcnt_r == 8'd149) ? 8'h00 : tcnt_r + 8'h01;
            hw_trigger_in <= trig_on && tcnt_r == 8'd149;
        end
    end
endmodule // adcc_front_model

/* adc_conversion_control_bench.sv */
// self-checking bench of the conversion controller
module adc_conversion_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, trig_on, ok;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic hreadyout, hresp, comp_in, hw_trigger_in, ref_high_input_en;
    logic ref_low_input_en, converter_power_en, sample_en, done_irq;
    logic [27:0] analog_input_en;
    logic [9:0] dac_trial, lv;
    logic [7:0] seed, rd, hi;
    logic [4:0] s;
    int fails, samples_checked;

    adcc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
        .hresp, .hw_trigger_in, .comp_in, .analog_input_en, .sample_en,
        .ref_high_input_en, .ref_low_input_en, .converter_power_en,
        .dac_trial, .done_irq);
    adcc_front_model u_front (.hclk, .hresetn, .analog_input_en,
        .ref_high_input_en, .ref_low_input_en, .sample_en, .dac_trial,
        .trig_on, .comp_in, .hw_trigger_in);

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [9:0] level(input logic [4:0] v);
        level = (v < 5'h1c) ? 10'(v) * 10'd37 + 10'd5 :
                (v == 5'h1d) ? 10'h3ff : 10'h000;
    endfunction

    task automatic give_verdict;
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // bus signals are sampled before the edge's own updates land
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata[7:0];
    endtask
    task automatic wait_done;
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            bus(1'b0, 8'h00, 8'h00);
            ok = rd[7];
        end
    endtask
    task automatic conv(input logic [4:0] v, input logic ie);
        bus(1'b1, 8'h00, {1'b0, ie, 1'b0, v});
        bus(1'b0, 8'h04, 8'h00);
        check(10'(rd[7]), 10'h001);
        wait_done;
        check(10'(ok), 10'h001);
        check(10'(done_irq), 10'(ie));
        bus(1'b0, 8'h0c, 8'h00);
        hi = rd;
        bus(1'b0, 8'h08, 8'h00);
        check({hi[1:0], rd}, level(v));
        bus(1'b0, 8'h00, 8'h00);
        check(10'(rd[7]), 10'h000);
        check(10'(converter_power_en), 10'h000);
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (60000) @(posedge hclk);
        fails++;
        give_verdict;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        trig_on = 1'b0;
        fails = 0;
        samples_checked = 0;
        seed = 8'h24;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 8'h00);
        check(10'(rd), 10'h01f);
        bus(1'b1, 8'h00, 8'h9f);
        bus(1'b0, 8'h00, 8'h00);
        check(10'(rd), 10'h01f);
        bus(1'b1, 8'h20, 8'h55);
        bus(1'b0, 8'h20, 8'h00);
        check(10'(rd), 10'h000);
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            s = (i == 0) ? 5'h00 : (i == 1) ? 5'h1b : (i == 2) ? 5'h1d :
                (i == 3) ? 5'h1e : (i == 4) ? 5'h1c : 5'(seed % 8'd28);
            conv(s, seed[0]);
        end
        bus(1'b1, 8'h00, 8'h02);
        repeat (20) @(posedge hclk);
        conv(5'h04, 1'b1);
        lv = level(5'h07);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h04, {2'b00, 1'b1, 1'(i >> 1), 4'h0});
            bus(1'b1, 8'h10, 8'(lv + 10'(i & 1)));
            bus(1'b1, 8'h14, {6'h00, 2'((lv + 10'(i & 1)) >> 8)});
            bus(1'b1, 8'h00, 8'h07);
            repeat (150) @(posedge hclk);
            bus(1'b0, 8'h00, 8'h00);
            check(10'(rd[7]), 10'(i == 1 || i == 2));
        end
        bus(1'b1, 8'h04, 8'h00);
        bus(1'b1, 8'h00, 8'h25);
        wait_done;
        bus(1'b0, 8'h08, 8'h00);
        wait_done;
        check(10'(ok), 10'h001);
        bus(1'b1, 8'h00, 8'h1f);
        repeat (150) @(posedge hclk);
        bus(1'b0, 8'h00, 8'h00);
        check(10'(rd), 10'h01f);
        bus(1'b1, 8'h04, 8'h40);
        bus(1'b1, 8'h00, 8'h09);
        repeat (200) @(posedge hclk);
        bus(1'b0, 8'h00, 8'h00);
        check(10'(rd[7]), 10'h000);
        trig_on <= 1'b1;
        wait_done;
        check(10'(ok), 10'h001);
        bus(1'b1, 8'h00, 8'h29);
        wait_done;
        bus(1'b0, 8'h08, 8'h00);
        wait_done;
        check(10'(ok), 10'h001);
        bus(1'b1, 8'h00, 8'h1f);
        trig_on <= 1'b0;
        repeat (20) @(posedge hclk);
        give_verdict;
    end
endmodule // adc_conversion_control_bench
